// file: logic/sfr_pkg.sv
// constants and types of the serial flash reset and security page block
package sfr_pkg;
	localparam logic [7:0] OP_WREN   = 8'h06;
	localparam logic [7:0] OP_WRDI   = 8'h04;
	localparam logic [7:0] OP_RSTEN  = 8'h66;
	localparam logic [7:0] OP_RST    = 8'h99;
	localparam logic [7:0] OP_UID    = 8'h4b;
	localparam logic [7:0] OP_SEC_ER = 8'h44;
	localparam logic [7:0] OP_SEC_PG = 8'h42;
	localparam logic [7:0] OP_SEC_RD = 8'h48;
	localparam logic [7:0] OP_RDSR   = 8'h05;
	localparam int CLK_MHZ     = 10;
	localparam int RST_TIME_US = 30;
	localparam logic [8:0] RST_CYC = 9'(RST_TIME_US * CLK_MHZ);
	localparam logic [19:0] BUSY_TAIL_CYC = 20'h00004;
	// value arbitrary, stands in for the factory number
	localparam logic [63:0] UID_VALUE = 64'h0123_4567_89ab_cdef;
	localparam logic [2:0] BYTES_ADDR = 3'h4;
	localparam logic [2:0] BYTES_DATA = 3'h5;
	localparam logic [2:0] LAST_BIT   = 3'h7;

	typedef enum logic [2:0] {PH_OPC, PH_ADDR, PH_DUMMY, PH_DATA, PH_IGN} sfr_phase_t;

	typedef struct packed {
		logic erase_suspended_flag;
		logic program_suspended_flag;
		logic write_enable_latch;
		logic ready_busy_flag;
	} sfr_status_t;

	typedef struct packed {
		logic                    cs_q1, cs_q2, cs_q3;
		logic                    sck_q1, sck_q2, sck_q3;
		logic                    si_q1, si_q2;
		logic                    wp_q1, wp_q2;
		sfr_phase_t              phase;
		logic [7:0]              opcode;
		logic [7:0]              sh;
		logic [2:0]              bitc;
		logic [2:0]              bytec;
		logic [2:0]              obit;
		logic [23:0]             addr;
		logic [9:0]              ptr;
		logic                    rej;
		logic                    armed;
		logic                    so;
		logic                    so_oe;
		logic                    wen_latch;
		logic                    busy;
		logic                    esus;
		logic                    psus;
		logic [19:0]             timer;
		logic [8:0]              rst_timer;
		logic                    rst_act;
		logic [7:0]              mode;
		logic [2:0]              wrap;
		logic [7:0]              prot;
		logic [255:0][7:0]       buffer;
		logic [2:0][255:0][7:0]  mem;
	} sfr_state_t;
endpackage : sfr_pkg

// file: logic/sfr_core.sv
// serial flash command slice: reset, unique number, security pages
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - wp pin low blocks every change to the protection bits
// - accepted reset clears all volatile state; 66h and 99h are refused while busy, so no running work is aborted
// - armed device disarms on any command other than 99h
// - reset lasts about 30 us, commands ignored meanwhile
// - 4Bh plus four dummy bytes, then 64-bit number out on falling edges
// - 44h plus three address bytes, erase starts when select rises
// - erase ignores A7-A0, aborts unless select rises right after A0
// - busy during erase, busy flag drops before erase fully ends
// - aborted or refused page erase clears write enable latch
// - lock bit set makes page permanent, erase ignored
// - page address: top byte 00h, bits 15-12 are 1h-3h, bits 11-8 0h
// - page program goes through the 256-byte buffer, overwriting it
// - 42h needs latch set, three address bytes, low byte is start
// - 48h, three address bytes, one dummy, then data every clock
// - read wraps from 0030FFh to 000000h with no gap
// - select rise ends a read at once, output released
// - 06h alone, select rising on a byte boundary, sets the latch
// - ready/busy flag is 1 while erase or program runs, 0 in its last 4 cycles, during reset and when ready
module sfr_core #(
	parameter int PAGE_WRITE_TIME_US = 1000
) (
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire logic                cs_n_i,
	input  wire logic                sck_i,
	input  wire logic                si_i,
	input  wire logic                wp_n_i,
	input  wire logic [2:0]          lock_bits_i,
	input  wire logic                prot_wr_i,
	input  wire logic [7:0]          prot_data_i,
	input  wire logic                vol_wr_i,
	input  wire logic [7:0]          mode_bits_i,
	input  wire logic [2:0]          wrap_bits_i,
	input  wire logic                erase_susp_set_i,
	input  wire logic                prog_susp_set_i,
	output logic                     so_o,
	output logic                     so_oe_o,
	output sfr_pkg::sfr_status_t     status_o,
	output logic [7:0]               continuous_read_mode_bits_o,
	output logic [2:0]               wrap_length_bits_o,
	output logic [7:0]               prot_bits_o,
	output logic                     reset_active_o
);
	localparam logic [19:0] PG_CYC = 20'(PAGE_WRITE_TIME_US * sfr_pkg::CLK_MHZ);

	sfr_pkg::sfr_state_t st;
	sfr_pkg::sfr_state_t n;
	logic       cs_act;
	logic       cs_rise;
	logic       rise;
	logic       fall;
	logic       byte_done;
	logic [7:0] b;
	logic [7:0] obyte;
	logic       so_bit;
	logic       ok_end;
	logic       rst_go;
	logic       er_go;
	logic       tgt_ok;
	logic       tgt_lock;

	function automatic logic sec_valid(input logic [23:0] a);
		sec_valid = (a[23:16] == 8'h00) && (a[11:8] == 4'h0) && (a[15:12] != 4'h0) && (a[15:12] <= 4'h3);
	endfunction : sec_valid

	function automatic logic [1:0] sec_idx(input logic [1:0] p);
		sec_idx = 2'(p - 2'h1);
	endfunction : sec_idx

////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = st;
		n.cs_q1  = cs_n_i;
		n.cs_q2  = st.cs_q1;
		n.cs_q3  = st.cs_q2;
		n.sck_q1 = sck_i;
		n.sck_q2 = st.sck_q1;
		n.sck_q3 = st.sck_q2;
		n.si_q1  = si_i;
		n.si_q2  = st.si_q1;
		n.wp_q1  = wp_n_i;
		n.wp_q2  = st.wp_q1;
		cs_act    = !st.cs_q2;
		cs_rise   = st.cs_q2 && !st.cs_q3;
		rise      = cs_act && st.sck_q2 && !st.sck_q3;
		fall      = cs_act && !st.sck_q2 && st.sck_q3;
		byte_done = rise && (st.bitc == sfr_pkg::LAST_BIT);
		b         = {st.sh[6:0], st.si_q2};
		ok_end    = (st.bitc == 3'h0) && !st.rej;
		tgt_ok    = sec_valid(st.addr);
		tgt_lock  = (st.addr[13:12] != 2'h0) && lock_bits_i[sec_idx(st.addr[13:12])];
		rst_go    = 1'b0;
		er_go     = 1'b0;
		case (st.opcode)
			sfr_pkg::OP_UID: obyte = 8'(sfr_pkg::UID_VALUE >> {~st.ptr[2:0], 3'h0});
			sfr_pkg::OP_RDSR: obyte = {6'h00, st.wen_latch, st.busy};
			default: obyte = (st.ptr[9:8] == 2'h0) ? 8'hff : st.mem[sec_idx(st.ptr[9:8])][st.ptr[7:0]];
		endcase
		so_bit = obyte[~st.obit];
		if (st.timer != 20'h0) begin
			n.timer = st.timer - 20'h1;
		end
		if (st.rst_timer != 9'h0) begin
			n.rst_timer = st.rst_timer - 9'h1;
		end
		if (erase_susp_set_i) begin
			n.esus = 1'b1;
		end
		if (prog_susp_set_i) begin
			n.psus = 1'b1;
		end
		if (vol_wr_i) begin
			n.mode = mode_bits_i;
			n.wrap = wrap_bits_i;
		end
		// hardware lock: synced pin low freezes the bits
		if (prot_wr_i && st.wp_q2) begin
			n.prot = prot_data_i;
		end
		if (!cs_act) begin
			n.so_oe = 1'b0;
			n.phase = sfr_pkg::PH_OPC;
			n.bitc  = 3'h0;
			n.bytec = 3'h0;
			n.obit  = 3'h0;
			n.rej   = 1'b0;
		end
		if (cs_rise) begin
			case (st.opcode)
				sfr_pkg::OP_WREN: begin
					if (ok_end && st.bytec == 3'h1) begin
						n.wen_latch = 1'b1;
					end
				end
				sfr_pkg::OP_WRDI: begin
					if (ok_end && st.bytec == 3'h1) begin
						n.wen_latch = 1'b0;
					end
				end
				sfr_pkg::OP_RSTEN: begin
					if (ok_end && st.bytec == 3'h1) begin
						n.armed = 1'b1;
					end
				end
				sfr_pkg::OP_RST: begin
					if (ok_end && st.bytec == 3'h1 && st.armed) begin
						rst_go = 1'b1;
					end
				end
				sfr_pkg::OP_SEC_ER: begin
					// no latch, no erase; any outcome drops the latch
					if (st.wen_latch && !st.rej) begin
						n.wen_latch = 1'b0;
						if (ok_end && st.bytec == sfr_pkg::BYTES_ADDR && tgt_ok && !tgt_lock) begin
							er_go = 1'b1;
							n.mem[sec_idx(st.addr[13:12])] = '1;
							n.timer = PG_CYC;
						end
					end
				end
				sfr_pkg::OP_SEC_PG: begin
					if (st.wen_latch && !st.rej) begin
						n.wen_latch = 1'b0;
						// programming only clears bits, buffer holds ones elsewhere
						if (ok_end && st.bytec >= sfr_pkg::BYTES_DATA && tgt_ok && !tgt_lock) begin
							n.mem[sec_idx(st.addr[13:12])] = st.mem[sec_idx(st.addr[13:12])] & st.buffer;
							n.timer = PG_CYC;
						end
					end
				end
				default: begin
				end
			endcase
		end
		if (rise) begin
			n.sh   = b;
			n.bitc = st.bitc + 3'h1;
		end
		if (byte_done) begin
			if (st.bytec != 3'h7) begin
				n.bytec = st.bytec + 3'h1;
			end
			case (st.phase)
				sfr_pkg::PH_OPC: begin
					n.opcode = b;
					n.phase  = sfr_pkg::PH_IGN;
					if (b != sfr_pkg::OP_RST) begin
						n.armed = 1'b0;
					end
					// no command taken while resetting, none but 05h while busy
					if (st.rst_timer != 9'h0 || (st.busy && b != sfr_pkg::OP_RDSR)) begin
						n.rej = 1'b1;
					end else begin
						case (b)
							sfr_pkg::OP_RDSR: n.phase = sfr_pkg::PH_DATA;
							sfr_pkg::OP_UID: begin
								n.phase = sfr_pkg::PH_DUMMY;
								n.ptr   = 10'h000;
							end
							sfr_pkg::OP_SEC_PG: begin
								n.phase  = sfr_pkg::PH_ADDR;
								n.buffer = '1;
							end
							sfr_pkg::OP_SEC_ER, sfr_pkg::OP_SEC_RD: n.phase = sfr_pkg::PH_ADDR;
							default: n.phase = sfr_pkg::PH_IGN;
						endcase
					end
				end
				sfr_pkg::PH_ADDR: begin
					n.addr = {st.addr[15:0], b};
					if (st.bytec == 3'h3) begin
						n.ptr = {st.addr[5:4], b};
						case (st.opcode)
							sfr_pkg::OP_SEC_RD: n.phase = sfr_pkg::PH_DUMMY;
							sfr_pkg::OP_SEC_PG: n.phase = sfr_pkg::PH_DATA;
							default: n.phase = sfr_pkg::PH_IGN;
						endcase
					end
				end
				sfr_pkg::PH_DUMMY: begin
					if (st.bytec == 3'h4) begin
						n.phase = sfr_pkg::PH_DATA;
					end
				end
				sfr_pkg::PH_DATA: begin
					if (st.opcode == sfr_pkg::OP_SEC_PG) begin
						n.buffer[st.addr[7:0]] = b;
						n.addr[7:0] = st.addr[7:0] + 8'h01;
					end
				end
				default: begin
				end
			endcase
		end
		if (fall && st.phase == sfr_pkg::PH_DATA && st.opcode != sfr_pkg::OP_SEC_PG) begin
			n.so_oe = 1'b1;
			n.so    = so_bit;
			n.obit  = st.obit + 3'h1;
			if (st.obit == sfr_pkg::LAST_BIT) begin
				n.ptr = st.ptr + 10'h001;
			end
		end
		if (rst_go) begin
			n.wen_latch = 1'b0;
			n.esus      = 1'b0;
			n.psus      = 1'b0;
			n.mode      = 8'h00;
			n.wrap      = 3'h0;
			n.timer     = 20'h0;
			n.armed     = 1'b0;
			n.rst_timer = sfr_pkg::RST_CYC;
		end
		// flag drops a few cycles ahead of the real end
		n.busy    = n.timer > sfr_pkg::BUSY_TAIL_CYC;
		n.rst_act = n.rst_timer != 9'h0;
	end

////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st        <= '0;
			st.cs_q1  <= 1'b1;
			st.cs_q2  <= 1'b1;
			st.cs_q3  <= 1'b1;
			st.wp_q1  <= 1'b1;
			st.wp_q2  <= 1'b1;
			st.buffer <= '1;
			st.mem    <= '1;
		end else begin
			st <= n;
		end
	end

	assign so_o                        = st.so;
	assign so_oe_o                     = st.so_oe;
	assign status_o                    = {st.esus, st.psus, st.wen_latch, st.busy};
	assign continuous_read_mode_bits_o = st.mode;
	assign wrap_length_bits_o          = st.wrap;
	assign prot_bits_o                 = st.prot;
	assign reset_active_o              = st.rst_act;

////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_rise_er;
		cs_rise && st.opcode == sfr_pkg::OP_SEC_ER && st.wen_latch && !st.rej;
	endsequence
	sequence s_rst_hold;
		st.rst_act [*8];
	endsequence

	property p_wp;
		!st.wp_q2 |=> st.prot == $past(st.prot);
	endproperty
	a_wp: assert property (p_wp) else $error("protection bits changed under wp low");
	property p_rst;
		rst_go |=> !st.wen_latch && !st.esus && !st.psus && st.mode == 8'h00 && st.wrap == 3'h0 && !st.busy;
	endproperty
	a_rst: assert property (p_rst) else $error("volatile state kept over reset");
	property p_rst_time;
		rst_go |=> st.rst_timer == sfr_pkg::RST_CYC ##0 s_rst_hold;
	endproperty
	a_rst_time: assert property (p_rst_time) else $error("reset interval wrong");
	property p_ign;
		byte_done && st.phase == sfr_pkg::PH_OPC && st.rst_timer != 9'h0 |=> st.rej;
	endproperty
	a_ign: assert property (p_ign) else $error("command taken during reset");
	property p_disarm;
		byte_done && st.phase == sfr_pkg::PH_OPC && b != sfr_pkg::OP_RST |=> !st.armed;
	endproperty
	a_disarm: assert property (p_disarm) else $error("reset arm kept");
	property p_out;
		fall && st.phase == sfr_pkg::PH_DATA && st.opcode == sfr_pkg::OP_UID
			|=> so_oe_o && so_o == sfr_pkg::UID_VALUE[~{$past(st.ptr[2:0]), $past(st.obit)}];
	endproperty
	a_out: assert property (p_out) else $error("number bit wrong");
	property p_er;
		s_rise_er |=> !st.wen_latch && (!$past(er_go) || st.busy);
	endproperty
	a_er: assert property (p_er) else $error("erase latch or busy wrong");
	property p_early;
		$fell(st.busy) && !st.rst_act |-> st.timer != 20'h0;
	endproperty
	a_early: assert property (p_early) else $error("busy did not drop early");
	property p_lock;
		cs_rise && (st.opcode == sfr_pkg::OP_SEC_ER || st.opcode == sfr_pkg::OP_SEC_PG) && tgt_lock |=> $stable(st.mem);
	endproperty
	a_lock: assert property (p_lock) else $error("locked page changed");
	property p_hiz;
		cs_rise |=> !so_oe_o;
	endproperty
	a_hiz: assert property (p_hiz) else $error("output held after select rise");
	property p_wrap;
		fall && st.phase == sfr_pkg::PH_DATA && st.opcode == sfr_pkg::OP_SEC_RD
			&& st.obit == sfr_pkg::LAST_BIT && st.ptr == 10'h3ff |=> st.ptr == 10'h000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("read wrap wrong");
endmodule : sfr_core

// file: test/sfr_host.sv
// host spi controller model: mode 0, select and clock driven by the host
`timescale 1ns/10ps
module sfr_host (
	input  wire logic clk_i,
	input  wire logic so_i,
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      si_o
);
	logic [7:0] rxq[$];
	logic [7:0] rx;
	initial begin
		cs_n_o = 1'b1;
		sck_o  = 1'b0;
		si_o   = 1'b0;
		rx     = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////////////
	// msb first, 800 ns a bit; so taken just before each rise, late enough for the synced answer
	task automatic frame(input logic [7:0] q[$], input int nbits);
		rxq = {};
		for (int j = 0; j < nbits; j++) begin
			@(negedge clk_i);
			cs_n_o = 1'b0;
			si_o   = q[j / 8][7 - j % 8];
			repeat (3) @(negedge clk_i);
			rx = {rx[6:0], so_i};
			if (j % 8 == 7)
				rxq.push_back(rx);
			sck_o = 1'b1;
			repeat (4) @(negedge clk_i);
			sck_o = 1'b0;
		end
		repeat (4) @(negedge clk_i);
		cs_n_o = 1'b1;
		// released line shows the inverse, never a held value
		si_o = ~si_o;
		repeat (8) @(negedge clk_i);
	endtask : frame
endmodule : sfr_host

// file: test/sfr_core_bench.sv
// self-checking bench of the reset and security page block
`timescale 1ns/10ps
module sfr_core_bench;
	logic                 clk_i = 1'b0;
	logic                 rst_n_i = 1'b0;
	logic                 cs_n, sck, si, so, so_oe, rst_act;
	logic                 wp_n = 1'b1;
	logic [2:0]           lock = 3'h0;
	logic                 prot_wr = 1'b0;
	logic [7:0]           prot_data = 8'h3c;
	logic                 vol_wr = 1'b0;
	logic                 esus = 1'b0;
	logic                 psus = 1'b0;
	sfr_pkg::sfr_status_t st;
	logic [7:0]           mode, prot;
	logic [2:0]           wrap;
	logic [63:0]          v;
	int                   num_errors = 0;
	int                   comparisons = 0;
	int                   cyc = 0;

	always #50 clk_i = ~clk_i;

	sfr_core #(.PAGE_WRITE_TIME_US(20)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sck_i(sck),
		.si_i(si), .wp_n_i(wp_n), .lock_bits_i(lock), .prot_wr_i(prot_wr), .prot_data_i(prot_data),
		.vol_wr_i(vol_wr), .mode_bits_i(8'ha5), .wrap_bits_i(3'h5), .erase_susp_set_i(esus),
		.prog_susp_set_i(psus), .so_o(so), .so_oe_o(so_oe), .status_o(st),
		.continuous_read_mode_bits_o(mode), .wrap_length_bits_o(wrap), .prot_bits_o(prot),
		.reset_active_o(rst_act));
	sfr_host host (.clk_i(clk_i), .so_i(so_oe ? so : 1'bz), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic send(input logic [7:0] q[$]);
		host.frame(q, q.size() * 8);
	endtask : send
	task automatic rd(input logic [23:0] a, input int n);
		logic [7:0] q[$];
		q = '{8'h48, a[23:16], a[15:8], a[7:0], 8'h00};
		repeat (n) q.push_back(8'h00);
		send(q);
	endtask : rd
	task automatic pulse(ref logic s);
		@(negedge clk_i);
		s = 1'b1;
		@(negedge clk_i);
		s = 1'b0;
	endtask : pulse
	// bounded wait: a busy flag stuck high counts as a mismatch, not a hang
	task automatic wait_ready();
		for (int i = 0; i < 400 && st.ready_busy_flag !== 1'b0; i++)
			@(negedge clk_i);
		chk("ready", 64'h0, st.ready_busy_flag);
	endtask : wait_ready
	task automatic final_report();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			num_errors++;
			final_report();
		end
	end

	initial begin
		repeat (5) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		send('{8'h4b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
		v = 64'h0;
		for (int k = 5; k < 13; k++)
			v = {v[55:0], host.rxq[k]};
		chk("unique number", sfr_pkg::UID_VALUE, v);
		send('{8'h06});
		send('{8'h05, 8'h00});
		chk("status byte", 64'h02, host.rxq[1]);
		send('{8'h42, 8'h00, 8'h10, 8'hfe, 8'ha5, 8'h5a, 8'h3c});
		chk("busy", 64'h1, st.ready_busy_flag);
		wait_ready();
		chk("latch", 64'h0, st.write_enable_latch);
		rd(24'h0010fe, 3);
		for (int k = 0; k < 3; k++)
			chk("page one", {8'ha5, 8'h5a, 8'hff} >> (16 - 8 * k) & 64'hff, host.rxq[5 + k]);
		// cut-off read: select rises three bits into the first data byte, output must be released
		host.frame('{8'h48, 8'h00, 8'h10, 8'hfe, 8'h00, 8'h00}, 43);
		chk("so released", 64'h0, so_oe);
		rd(24'h0030ff, 258);
		for (int k = 0; k < 258; k++)
			chk("wrap read", k == 257 ? 64'h3c : 64'hff, host.rxq[5 + k]);
		// locked page refuses both erase and program
		lock = 3'h1;
		send('{8'h06});
		send('{8'h44, 8'h00, 8'h10, 8'h00});
		chk("locked busy", 64'h0, st.ready_busy_flag);
		send('{8'h06});
		send('{8'h42, 8'h00, 8'h10, 8'hfe, 8'h00});
		lock = 3'h0;
		send('{8'h44, 8'h00, 8'h10, 8'h55});
		rd(24'h0010fe, 1);
		chk("locked page", 64'ha5, host.rxq[5]);
		send('{8'h06});
		host.frame('{8'h44, 8'h00, 8'h10, 8'h55, 8'h00}, 35);
		chk("abort latch", 64'h0, st.write_enable_latch);
		rd(24'h0010fe, 1);
		chk("kept page", 64'ha5, host.rxq[5]);
		send('{8'h06});
		send('{8'h42, 8'h00, 8'h40, 8'h00, 8'h00});
		chk("bad address", 64'h0, st.ready_busy_flag);
		send('{8'h06});
		send('{8'h44, 8'h00, 8'h10, 8'h55});
		chk("erase busy", 64'h1, st.ready_busy_flag);
		send('{8'h05, 8'h00});
		chk("erase status", 64'h01, host.rxq[1]);
		wait_ready();
		rd(24'h0010fe, 1);
		chk("erased", 64'hff, host.rxq[5]);
		pulse(prot_wr);
		wp_n = 1'b0;
		prot_data = 8'hc3;
		repeat (4) @(negedge clk_i);
		pulse(prot_wr);
		repeat (3) @(negedge clk_i);
		chk("protection", 64'h3c, prot);
		wp_n = 1'b1;
		pulse(vol_wr);
		pulse(esus);
		pulse(psus);
		chk("volatile set", {4'hc, 8'ha5, 3'h5}, {st, mode, wrap});
		send('{8'h06});
		send('{8'h66});
		send('{8'h05, 8'h00});
		send('{8'h99});
		chk("disarmed", 64'h0, rst_act);
		chk("idle before reset", 64'h0, st.ready_busy_flag);
		send('{8'h66});
		send('{8'h99});
		chk("resetting", 64'h1, rst_act);
		chk("volatile", 64'h0, {st, mode, wrap});
		send('{8'h06});
		chk("ignored", 64'h0, st.write_enable_latch);
		for (int i = 0; i < 400 && rst_act !== 1'b0; i++)
			@(negedge clk_i);
		chk("reset done", 64'h0, rst_act);
		send('{8'h06});
		chk("after reset", 64'h1, st.write_enable_latch);
		final_report();
	end
endmodule : sfr_core_bench
